// *** hw/scsf_pkg.sv ***
package scsf_pkg;

    // build-time limits of the buffer geometry
    localparam int SCSF_WIDTH_MIN = 4;
    localparam int SCSF_WIDTH_MAX = 80;
    localparam int SCSF_DEPTH_MIN = 16;
    localparam int SCSF_DEPTH_MAX = 256;
    localparam int SCSF_DEPTH_STEP = 16;

    // register bus geometry
    localparam int SCSF_BUS_AW = 4;
    localparam int SCSF_BUS_DW = 32;
    localparam int SCSF_BUS_BE = 4;

    // register byte offsets
    localparam logic [3:0] SCSF_OFS_CTRL = 4'h0;
    localparam logic [3:0] SCSF_OFS_STATUS = 4'h4;
    localparam logic [3:0] SCSF_OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] SCSF_OFS_IRQ_MASK = 4'hc;

    // control register: hold freezes both strobes
    localparam int SCSF_CTRL_HOLD_BIT = 0;
    localparam logic SCSF_CTRL_HOLD_RST = 1'b0;

    // status register fields
    localparam int SCSF_STAT_EMPTY_BIT = 0;
    localparam int SCSF_STAT_FULL_BIT = 1;
    localparam int SCSF_STAT_HOLD_BIT = 2;
    localparam int SCSF_STAT_LEVEL_LSB = 16;

    // interrupt status and mask share this layout
    localparam int SCSF_IRQ_W = 2;
    localparam int SCSF_IRQ_FULL_BIT = 0;
    localparam int SCSF_IRQ_EMPTY_BIT = 1;
    localparam logic [1:0] SCSF_IRQ_STAT_RST = 2'h0;
    localparam logic [1:0] SCSF_IRQ_MASK_RST = 2'h0;

    // accepted operations of one cycle
    typedef struct packed {
        logic push;
        logic pop;
    } scsf_op_s;

    // one register bus request as the slave sees it
    typedef struct packed {
        logic read;
        logic write;
        logic [SCSF_BUS_AW-1:0] address;
        logic [SCSF_BUS_DW-1:0] writedata;
        logic [SCSF_BUS_BE-1:0] byteenable;
    } scsf_bus_req_s;

    // bus slave answer phase
    typedef enum logic [0:0] {
        SCSF_BUS_IDLE = 1'b0,
        SCSF_BUS_ANSWER = 1'b1
    } scsf_bus_state_e;

endpackage : scsf_pkg

// *** hw/scsf_store.sv ***
`timescale 1ns/100ps
// word storage in flip-flops; one write port, one combinational read port
module scsf_store
    import scsf_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // clock
    input wire logic i_sys_clk,
    // write port
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    // read port
    input wire logic [AW-1:0] i_rd_addr,
    output logic [DATA_W-1:0] o_rd_word
);

    // storage words; no reset, the pointers decide what is valid
    logic [DATA_W-1:0] mem [DEPTH];

    // one write decoder per word keeps each slot a plain enable flop
    for (genvar g = 0; g < DEPTH; g++) begin : g_word
        always_ff @(posedge i_sys_clk) begin
            if (i_wr_en && (i_wr_addr == AW'(g))) begin
                mem[g] <= i_wr_data;
            end
        end
    end

    // read is asynchronous; the top registers it
    assign o_rd_word = mem[i_rd_addr];

endmodule : scsf_store

// *** hw/scsf_top.sv ***
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
// Function
// - reset pulse empties the buffer
// - accepted push stores the input word
// - accepted pop loads oldest word out
// - words leave in written order
// - full high when every slot holds data
// - empty high when nothing is held
// - push ignored while full
// - pop ignored while empty
// - dropped strobes raise no error
// - single port: push blocks pop, pop blocks push
// - dual port: push and pop together
// - storage port count is a build parameter
// - word width parameter, 4 to 80
// - depth parameter 16 to 256, step 16
// - direction high for write, low read
module scsf_top
    import scsf_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int DEPTH = 32,
    parameter bit DUAL_PORT = 1'b1
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // producer side
    input wire logic i_push_strobe,
    input wire logic [DATA_W-1:0] i_wr_data,
    // consumer side
    input wire logic i_pop_strobe,
    output logic [DATA_W-1:0] o_rd_data,
    // fill flags
    output logic o_full,
    output logic o_empty,
    // external level counter
    output logic o_level_counter_enable,
    output logic o_level_counter_direction,
    // register bus slave
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [SCSF_BUS_AW-1:0] i_avs_address,
    input wire logic [SCSF_BUS_DW-1:0] i_avs_writedata,
    input wire logic [SCSF_BUS_BE-1:0] i_avs_byteenable,
    output logic [SCSF_BUS_DW-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // interrupt
    output logic o_irq
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW-1:0] PTR_ZERO = AW'(0);

    // refuse geometries the logic cannot serve
    if (DATA_W < SCSF_WIDTH_MIN || DATA_W > SCSF_WIDTH_MAX) begin : g_bad_width
        $error("scsf_top: DATA_W out of range");
    end
    if (DEPTH < SCSF_DEPTH_MIN || DEPTH > SCSF_DEPTH_MAX || (DEPTH % SCSF_DEPTH_STEP) != 0) begin : g_bad_depth
        $error("scsf_top: DEPTH out of range or not a multiple of the step");
    end

    // pointer advance with wrap; depth need not be a power of two
    function automatic logic [AW-1:0] scsf_next_ptr(input logic [AW-1:0] p);
        scsf_next_ptr = (p == PTR_LAST) ? PTR_ZERO : p + AW'(1);
    endfunction : scsf_next_ptr

    // register offset match, used for read and write decode
    function automatic logic scsf_hit(input logic [SCSF_BUS_AW-1:0] a, input logic [SCSF_BUS_AW-1:0] ofs);
        scsf_hit = (a == ofs);
    endfunction : scsf_hit

    // buffer state
    logic [AW-1:0] wr_ptr; // next slot to write
    logic [AW-1:0] rd_ptr; // oldest stored word
    logic [CW-1:0] cnt; // words held
    logic [DATA_W-1:0] store_word; // word at rd_ptr

    // software state
    logic ctrl_hold; // freezes both strobes
    logic [SCSF_IRQ_W-1:0] irq_stat; // sticky events
    logic [SCSF_IRQ_W-1:0] irq_mask; // enables onto o_irq
    scsf_bus_state_e bus_state; // answer phase of the slave

    // acceptance: gated by flags, hold and, for single port, the other strobe
    scsf_op_s op;
    logic port_free_push;
    logic port_free_pop;
    assign port_free_push = DUAL_PORT | ~i_pop_strobe;
    assign port_free_pop = DUAL_PORT | ~i_push_strobe;
    // a full buffer drops the push silently, no error flag exists
    assign op.push = i_push_strobe & ~o_full & ~ctrl_hold & port_free_push;
    // an empty buffer drops the pop silently
    assign op.pop = i_pop_strobe & ~o_empty & ~ctrl_hold & port_free_pop;

    // next fill count and flags
    logic [CW-1:0] next_cnt;
    logic next_full;
    logic next_empty;
    assign next_cnt = (op.push && !op.pop) ? cnt + CNT_ONE :
                      (op.pop && !op.push) ? cnt - CNT_ONE : cnt;
    assign next_full = (next_cnt == CNT_FULL);
    assign next_empty = (next_cnt == '0);

    // storage; write only on an accepted push
    scsf_store #(
        .DATA_W(DATA_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_store (
        .i_sys_clk(i_sys_clk),
        .i_wr_en(op.push),
        .i_wr_addr(wr_ptr),
        .i_wr_data(i_wr_data),
        .i_rd_addr(rd_ptr),
        .o_rd_word(store_word)
    );

    // pointers move one slot per accepted operation, so order holds
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wr_ptr <= PTR_ZERO;
            rd_ptr <= PTR_ZERO;
            cnt <= '0;
        end else begin
            if (op.push) begin
                wr_ptr <= scsf_next_ptr(wr_ptr);
            end
            if (op.pop) begin
                rd_ptr <= scsf_next_ptr(rd_ptr);
            end
            cnt <= next_cnt;
        end
    end

    // flags registered from the next count so they match cnt
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_full <= 1'b0;
            o_empty <= 1'b1;
        end else begin
            o_full <= next_full;
            o_empty <= next_empty;
        end
    end

    // output register loads only on an accepted pop, else holds
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rd_data <= '0;
        end else if (op.pop) begin
            o_rd_data <= store_word;
        end
    end

    // level counter drive; simultaneous push and pop cancel out
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_level_counter_enable <= 1'b0;
            o_level_counter_direction <= 1'b0;
        end else begin
            o_level_counter_enable <= op.push ^ op.pop;
            if (op.push ^ op.pop) begin
                o_level_counter_direction <= op.push;
            end
        end
    end

    // register bus: one wait cycle, then one answer cycle
    scsf_bus_req_s req;
    logic bus_start;
    logic bus_commit_wr;
    logic [SCSF_BUS_DW-1:0] rd_word;
    assign req = '{read: i_avs_read, write: i_avs_write, address: i_avs_address,
                   writedata: i_avs_writedata, byteenable: i_avs_byteenable};
    assign bus_start = (bus_state == SCSF_BUS_IDLE) & (req.read | req.write);
    // writes land at the edge where waitrequest is seen low
    assign bus_commit_wr = (bus_state == SCSF_BUS_ANSWER) & req.write & req.byteenable[0];

    // read decode; unmapped offsets read zero
    always_comb begin
        rd_word = '0;
        if (scsf_hit(req.address, SCSF_OFS_CTRL)) begin
            rd_word[SCSF_CTRL_HOLD_BIT] = ctrl_hold;
        end else if (scsf_hit(req.address, SCSF_OFS_STATUS)) begin
            rd_word[SCSF_STAT_EMPTY_BIT] = o_empty;
            rd_word[SCSF_STAT_FULL_BIT] = o_full;
            rd_word[SCSF_STAT_HOLD_BIT] = ctrl_hold;
            rd_word[SCSF_STAT_LEVEL_LSB +: CW] = cnt;
        end else if (scsf_hit(req.address, SCSF_OFS_IRQ_STAT)) begin
            rd_word[SCSF_IRQ_W-1:0] = irq_stat;
        end else if (scsf_hit(req.address, SCSF_OFS_IRQ_MASK)) begin
            rd_word[SCSF_IRQ_W-1:0] = irq_mask;
        end
    end

    // slave handshake; readdata is captured before the answer cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bus_state <= SCSF_BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= '0;
        end else begin
            case (bus_state)
                SCSF_BUS_IDLE: begin
                    if (bus_start) begin
                        bus_state <= SCSF_BUS_ANSWER;
                        o_avs_waitrequest <= 1'b0;
                        o_avs_readdata <= rd_word;
                    end
                end
                default: begin
                    bus_state <= SCSF_BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // control and mask registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ctrl_hold <= SCSF_CTRL_HOLD_RST;
            irq_mask <= SCSF_IRQ_MASK_RST;
        end else if (bus_commit_wr) begin
            if (scsf_hit(req.address, SCSF_OFS_CTRL)) begin
                ctrl_hold <= req.writedata[SCSF_CTRL_HOLD_BIT];
            end else if (scsf_hit(req.address, SCSF_OFS_IRQ_MASK)) begin
                irq_mask <= req.writedata[SCSF_IRQ_W-1:0];
            end
        end
    end

    // sticky events: reaching full, draining to empty; set beats clear
    logic [SCSF_IRQ_W-1:0] evt;
    logic [SCSF_IRQ_W-1:0] w1c;
    logic [SCSF_IRQ_W-1:0] next_irq_stat;
    assign evt[SCSF_IRQ_FULL_BIT] = next_full & ~o_full;
    assign evt[SCSF_IRQ_EMPTY_BIT] = next_empty & ~o_empty;
    assign w1c = (bus_commit_wr && scsf_hit(req.address, SCSF_OFS_IRQ_STAT)) ?
                 req.writedata[SCSF_IRQ_W-1:0] : '0;
    assign next_irq_stat = (irq_stat & ~w1c) | evt;
    // mask as it stands after this edge, so a mask write moves o_irq at once
    logic [SCSF_IRQ_W-1:0] next_irq_mask;
    assign next_irq_mask = (bus_commit_wr && scsf_hit(req.address, SCSF_OFS_IRQ_MASK)) ?
                           req.writedata[SCSF_IRQ_W-1:0] : irq_mask;

    // interrupt status and level output, both registered
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_stat <= SCSF_IRQ_STAT_RST;
            o_irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            o_irq <= |(next_irq_stat & next_irq_mask);
        end
    end

    // checks on the buffer behaviour
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    property p_reset_state;
        @(posedge i_sys_clk) disable iff (1'b0)
        i_rst |=> (o_empty && !o_full && !o_level_counter_enable && cnt == '0);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");

    property p_push_counts;
        (op.push && !op.pop) |=> (cnt == $past(cnt) + CNT_ONE) && (wr_ptr == scsf_next_ptr($past(wr_ptr)));
    endproperty
    a_push_counts: assert property (p_push_counts) else $error("push not stored");

    property p_pop_loads;
        op.pop |=> (o_rd_data == $past(store_word));
    endproperty
    a_pop_loads: assert property (p_pop_loads) else $error("pop did not load oldest word");

    property p_ptr_order;
        (cnt == CNT_FULL && wr_ptr == rd_ptr) || (cnt == '0 && wr_ptr == rd_ptr) || (cnt != '0 && cnt != CNT_FULL);
    endproperty
    a_ptr_order: assert property (p_ptr_order) else $error("pointers disagree with count");

    property p_full_flag;
        o_full == (cnt == CNT_FULL);
    endproperty
    a_full_flag: assert property (p_full_flag) else $error("full flag wrong");

    property p_empty_flag;
        o_empty == (cnt == '0);
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong");

    property p_full_blocks;
        (o_full && !op.pop) |=> (o_full && $stable(wr_ptr));
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("write while full");

    property p_empty_blocks;
        (o_empty && !op.push) |=> (o_empty && $stable(o_rd_data));
    endproperty
    a_empty_blocks: assert property (p_empty_blocks) else $error("read while empty");

    property p_single_port;
        (!DUAL_PORT && i_push_strobe && i_pop_strobe) |-> (!op.push && !op.pop);
    endproperty
    a_single_port: assert property (p_single_port) else $error("single port did both");

    property p_dual_both;
        (DUAL_PORT && i_push_strobe && i_pop_strobe && !o_full && !o_empty && !ctrl_hold)
            |-> op.push && op.pop ##1 $stable(cnt);
    endproperty
    a_dual_both: assert property (p_dual_both) else $error("dual port missed an operation");

    property p_level_dir;
        (op.push ^ op.pop) |=> o_level_counter_enable && (o_level_counter_direction == $past(op.push));
    endproperty
    a_level_dir: assert property (p_level_dir) else $error("level counter drive wrong");

    property p_level_cancel;
        (op.push == op.pop) |=> !o_level_counter_enable;
    endproperty
    a_level_cancel: assert property (p_level_cancel) else $error("level enable without net change");

    // an event always lands in the sticky status, even against a clear in the same cycle
    property p_evt_sticky;
        (|evt) |=> ((irq_stat & $past(evt)) == $past(evt));
    endproperty
    a_evt_sticky: assert property (p_evt_sticky) else $error("event lost from interrupt status");

    // the interrupt line tracks status and mask without a lag
    property p_irq_level;
        o_irq == |(irq_stat & irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt line disagrees with status and mask");

    // main scenarios worth seeing
    c_fill_up: cover property (op.push ##1 o_full);
    c_drain: cover property (op.pop ##1 o_empty);
    c_both: cover property (op.push && op.pop);
    c_irq: cover property ($rose(o_irq));

endmodule : scsf_top

// *** test/scsf_level_model.sv ***
`timescale 1ns/100ps
// external up/down counter that user logic hangs on the level outputs
module scsf_level_model
    import scsf_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // count request from the buffer
    input wire logic i_level_counter_enable,
    input wire logic i_level_counter_direction,
    // tracked fill level
    output logic [8:0] o_level
);
    // reset together with the buffer, since the buffer sends no count on reset
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_level <= 9'h000;
        end else if (i_level_counter_enable) begin
            // up for a write, down for a read
            o_level <= i_level_counter_direction ? o_level + 9'h001 : o_level - 9'h001;
        end
    end
endmodule : scsf_level_model

// *** test/scsf_top_tb.sv ***
`timescale 1ns/100ps
module scsf_top_tb
    import scsf_pkg::*;
;
    localparam int DW = 8;
    localparam int DEPTH = 16;
    // stimulus, all but the clock driven by non-blocking assignment at the rising edge
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic push = 1'b0;
    logic pop = 1'b0;
    logic [DW-1:0] wdata = 8'h00;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [SCSF_BUS_AW-1:0] avs_addr = 4'h0;
    logic [SCSF_BUS_DW-1:0] avs_wd = 32'h0;
    logic [SCSF_BUS_BE-1:0] avs_be = 4'h0;
    // design and partner outputs
    logic [DW-1:0] rd_data;
    logic full, empty, lvl_en, lvl_dir, waitreq, irq;
    logic [SCSF_BUS_DW-1:0] avs_rdata;
    logic [8:0] level;
    // reference model: queue of stored words and what was last driven
    logic [DW-1:0] q[$];
    logic [DW-1:0] exp_rd = 8'h00;
    logic [DW-1:0] cur_d = 8'h00;
    logic cur_p = 1'b0;
    logic cur_q = 1'b0;
    logic hold = 1'b0;
    // single-port twin: arbitration switch, its outputs and its own reference queue
    logic arb_on = 1'b1;
    logic arb_next = 1'b1;
    logic cur_arb = 1'b1;
    logic sp_pop;
    logic [DW-1:0] sp_rd_data;
    logic sp_full, sp_empty, sp_lvl_en, sp_lvl_dir;
    logic [DW-1:0] q2[$];
    logic [DW-1:0] exp_rd2 = 8'h00;
    logic [SCSF_BUS_DW-1:0] rdv;
    integer seed = 32'h8931eb60;
    int fails = 0;
    int n_tests = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    scsf_top #(.DATA_W(DW), .DEPTH(DEPTH), .DUAL_PORT(1'b1)) i_scsf_top (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_push_strobe(push), .i_wr_data(wdata),
        .i_pop_strobe(pop), .o_rd_data(rd_data), .o_full(full), .o_empty(empty),
        .o_level_counter_enable(lvl_en), .o_level_counter_direction(lvl_dir),
        .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_address(avs_addr),
        .i_avs_writedata(avs_wd), .i_avs_byteenable(avs_be), .o_avs_readdata(avs_rdata),
        .o_avs_waitrequest(waitreq), .o_irq(irq));

    scsf_level_model i_scsf_level_model (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_level_counter_enable(lvl_en),
        .i_level_counter_direction(lvl_dir), .o_level(level));

    // user arbitration in front of the single-port twin: push wins, pop waits
    assign sp_pop = pop & ~(push & arb_on);

    // single-port twin on the same stimulus; bus answers and irq are checked on the first instance
    scsf_top #(.DATA_W(DW), .DEPTH(DEPTH), .DUAL_PORT(1'b0)) i_scsf_top_sp (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_push_strobe(push), .i_wr_data(wdata),
        .i_pop_strobe(sp_pop), .o_rd_data(sp_rd_data), .o_full(sp_full), .o_empty(sp_empty),
        .o_level_counter_enable(sp_lvl_en), .o_level_counter_direction(sp_lvl_dir),
        .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_address(avs_addr),
        .i_avs_writedata(avs_wd), .i_avs_byteenable(avs_be), .o_avs_readdata(),
        .o_avs_waitrequest(), .o_irq());

    // expected status word from the model
    function automatic logic [31:0] status_exp();
        logic [31:0] s;
        s = 32'h0;
        s[SCSF_STAT_EMPTY_BIT] = (q.size() == 0);
        s[SCSF_STAT_FULL_BIT] = (q.size() == DEPTH);
        s[SCSF_STAT_HOLD_BIT] = hold;
        s[24:16] = 9'(q.size());
        return s;
    endfunction : status_exp

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one cycle: account the strobes sampled at this edge, drive the next ones
    task automatic step(input logic p, input logic qq, input logic [DW-1:0] d);
        logic pa, qa, pa2, qa2, sq;
        logic [8:0] cb;
        @(posedge sys_clk);
        cb = 9'(q.size());
        pa = cur_p && q.size() < DEPTH && !hold;
        qa = cur_q && q.size() > 0 && !hold;
        // the twin sees pop only where the arbitration let it through
        sq = cur_q && !(cur_p && cur_arb);
        pa2 = cur_p && !sq && q2.size() < DEPTH && !hold;
        qa2 = sq && !cur_p && q2.size() > 0 && !hold;
        // pop sees the count before this edge's push
        if (qa) exp_rd = q.pop_front();
        if (pa) q.push_back(cur_d);
        if (qa2) exp_rd2 = q2.pop_front();
        if (pa2) q2.push_back(cur_d);
        push <= p;
        pop <= qq;
        wdata <= d;
        arb_on <= arb_next;
        cur_p = p;
        cur_q = qq;
        cur_d = d;
        cur_arb = arb_next;
        #1;
        chk(rd_data, exp_rd);
        chk(empty, q.size() == 0);
        chk(full, q.size() == DEPTH);
        chk(lvl_en, pa ^ qa);
        if (pa ^ qa) chk(lvl_dir, pa);
        chk(level, cb);
        chk(sp_rd_data, exp_rd2);
        chk(sp_empty, q2.size() == 0);
        chk(sp_full, q2.size() == DEPTH);
        chk(sp_lvl_en, pa2 ^ qa2);
        if (pa2 ^ qa2) chk(sp_lvl_dir, pa2);
    endtask : step

    // one bus transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_rd <= !w;
        avs_wr <= w;
        avs_addr <= a;
        avs_wd <= d;
        avs_be <= be;
        // no cycle count assumed: only the watchdog ends a wait that never comes
        do begin
            @(posedge sys_clk);
        end while (waitreq !== 1'b0);
        rdv = avs_rdata;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
    endtask : bus

    // irq moves at the edge where the write lands; look one edge later, when it has settled
    task automatic irq_chk(input logic exp);
        @(posedge sys_clk);
        #1;
        chk(irq, exp);
    endtask : irq_chk

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // watchdog: the whole run needs about 520 cycles, so this leaves ample margin
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        stop_test();
    end

    // main sequence
    initial begin
        logic [31:0] r;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        step(1'b0, 1'b0, 8'h00);
        done("reset");
        // fill past full, pop attempt first while empty
        step(1'b1, 1'b1, 8'h5a);
        for (int i = 0; i < DEPTH + 2; i++) step(1'b1, 1'b0, DW'($random(seed)));
        step(1'b0, 1'b0, 8'h00);
        bus(1'b0, SCSF_OFS_STATUS, 32'h0, 4'hf);
        chk(rdv, status_exp());
        bus(1'b0, SCSF_OFS_IRQ_STAT, 32'h0, 4'hf);
        chk(rdv, 32'h1);
        chk(irq, 1'b0);
        bus(1'b0, 4'h2, 32'h0, 4'hf);
        chk(rdv, 32'h0);
        bus(1'b1, SCSF_OFS_IRQ_MASK, 32'h3, 4'h1);
        irq_chk(1'b1);
        bus(1'b1, SCSF_OFS_IRQ_MASK, 32'h0, 4'h0);
        irq_chk(1'b1);
        bus(1'b0, SCSF_OFS_IRQ_MASK, 32'h0, 4'hf);
        chk(rdv, 32'h3);
        bus(1'b1, SCSF_OFS_IRQ_STAT, 32'h1, 4'h1);
        irq_chk(1'b0);
        done("fill");
        // drain past empty with a full-time pop
        for (int i = 0; i < DEPTH + 2; i++) step(1'b0, 1'b1, 8'h00);
        step(1'b0, 1'b0, 8'h00);
        bus(1'b0, SCSF_OFS_IRQ_STAT, 32'h0, 4'hf);
        chk(rdv, 32'h2);
        chk(irq, 1'b1);
        bus(1'b1, SCSF_OFS_IRQ_STAT, 32'h2, 4'h1);
        irq_chk(1'b0);
        done("drain");
        // hold freezes both strobes silently
        bus(1'b1, SCSF_OFS_CTRL, 32'h1, 4'h1);
        hold = 1'b1;
        for (int i = 0; i < 12; i++) step(1'b1, 1'b1, DW'($random(seed)));
        step(1'b0, 1'b0, 8'h00);
        bus(1'b0, SCSF_OFS_STATUS, 32'h0, 4'hf);
        chk(rdv, status_exp());
        bus(1'b0, SCSF_OFS_CTRL, 32'h0, 4'hf);
        chk(rdv, 32'h1);
        bus(1'b1, SCSF_OFS_CTRL, 32'h0, 4'h1);
        hold = 1'b0;
        done("hold");
        // random mix, push and pop often together at the edges of full and empty
        for (int i = 0; i < 400; i++) begin
            r = $random(seed);
            step(r[0] | r[2], r[1] | (r[3] & r[4]), r[15:8]);
        end
        done("random");
        // arbitration off: the single-port twin sees both strobes and must do neither
        arb_next = 1'b0;
        for (int i = 0; i < 6; i++) step(1'b1, 1'b1, DW'($random(seed)));
        arb_next = 1'b1;
        done("single port clash");
        // reset in mid-run with words stored
        for (int i = 0; i < 5; i++) step(1'b1, 1'b0, DW'($random(seed)));
        step(1'b0, 1'b0, 8'h00);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        q.delete();
        q2.delete();
        exp_rd = 8'h00;
        exp_rd2 = 8'h00;
        step(1'b1, 1'b0, 8'hc3);
        step(1'b0, 1'b1, 8'h00);
        step(1'b0, 1'b0, 8'h00);
        step(1'b0, 1'b0, 8'h00);
        done("reset mid-run");
        stop_test();
    end
endmodule : scsf_top_tb
